/* design/kes_cfg.svh */
// Register offsets and reset values of the keypad event status registers.
`ifndef KES_CFG_SVH
`define KES_CFG_SVH
`define KES_ADDR_REL_LO   8'h22
`define KES_ADDR_REL_HI   8'h23
`define KES_ADDR_LIVE_LO  8'h24
`define KES_ADDR_LIVE_HI  8'h25
`define KES_RST_FLAGS     8'h00
`define KES_RST_LIVE      16'h0000
`define KES_UNMAPPED_DATA 8'h00
`endif

/* design/kes_pkg.sv */
// Types shared by the keypad event status registers.
package kes_pkg;
  typedef logic [7:0]  kes_byte_t;
  typedef logic [15:0] kes_keys_t;
endpackage

/* design/kes_flag_byte.sv */
// One byte of sticky release flags, cleared by a read of its register.
`timescale 1ns/1ps
`default_nettype none
module kes_flag_byte #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // Events and read clear
  input  wire logic [W-1:0] set_in,
  input  wire logic         rd_clr_in,
  // Flag state
  output var  logic [W-1:0] flags_out
);
  logic [W-1:0] flags_ff;
  logic [W-1:0] nxt_flags;

  // Only the bits that the read returns are cleared, and a release in the
  // read cycle is ORed in after the clear so that it is kept for next time.
  always_comb begin
    nxt_flags = flags_ff;
    if (rd_clr_in) begin
      nxt_flags = '0; // RULE4
    end
    nxt_flags = nxt_flags | set_in; // RULE8
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_ff <= '0; // RULE3
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags_out = flags_ff;
endmodule
`default_nettype wire

/* design/kes_top.sv */
// Keypad release-event and live key-state status registers.
//
// Overview of operation
// RULE1: Register 0x22 bits 7 to 0 latch a release of keys A to H in order.
// RULE2: Register 0x23 bits 7 to 0 latch a release of keys I to P in order.
// RULE3: A release flag reads zero while no release of its key is pending.
// RULE4: Reading a release register clears its set flags; writes never do.
// RULE5: Register 0x24 shows keys A to H held down as ones, key A in bit 7.
// RULE6: A live bit reads zero for a key not held and is never latched.
// RULE7: Register 0x25 shows keys I to P held down, key I in bit 7.
// RULE8: A flag sets on a pressed-to-released change and survives a read.
`timescale 1ns/1ps
`default_nettype none
`include "kes_cfg.svh"
module kes_top (
  // Clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RSTN_IN,
  // Debounced key state from the scanner, bit 15 is key A, bit 0 key P
  input  wire logic [15:0] KEY_STATE_IN,
  // Register read port from the serial control interface
  input  wire logic        REG_RD_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  // Read answer
  output var  logic [7:0]  RD_DATA_OUT,
  output var  logic        RD_VALID_OUT
);
  kes_pkg::kes_keys_t live_ff;
  kes_pkg::kes_keys_t nxt_live;
  kes_pkg::kes_keys_t rel_evt;
  kes_pkg::kes_byte_t flags_lo;
  kes_pkg::kes_byte_t flags_hi;
  kes_pkg::kes_byte_t rd_data_ff;
  kes_pkg::kes_byte_t nxt_rd_data;
  logic               rd_valid_ff;
  logic               nxt_rd_valid;
  logic               rd_lo;
  logic               rd_hi;
  logic               rd_live_lo;
  logic               rd_live_hi;

  assign rd_lo      = REG_RD_IN && (REG_ADDR_IN == `KES_ADDR_REL_LO);
  assign rd_hi      = REG_RD_IN && (REG_ADDR_IN == `KES_ADDR_REL_HI);
  assign rd_live_lo = REG_RD_IN && (REG_ADDR_IN == `KES_ADDR_LIVE_LO);
  assign rd_live_hi = REG_RD_IN && (REG_ADDR_IN == `KES_ADDR_LIVE_HI);

  // Live state tracks the key every cycle; a held bit that drops is a release.
  // The reset value of zero means no release can be seen right after reset.
  always_comb begin
    nxt_live = KEY_STATE_IN; // RULE6
    rel_evt  = live_ff & ~KEY_STATE_IN; // RULE8
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      live_ff <= `KES_RST_LIVE;
    end else begin
      live_ff <= nxt_live;
    end
  end

  kes_flag_byte #(
    .W(8)
  ) u_flags_lo (
    .clk_in   (CORE_CLK_IN),
    .rstn_in  (RSTN_IN),
    .set_in   (rel_evt[15:8]), // RULE1
    .rd_clr_in(rd_lo),
    .flags_out(flags_lo)
  );

  kes_flag_byte #(
    .W(8)
  ) u_flags_hi (
    .clk_in   (CORE_CLK_IN),
    .rstn_in  (RSTN_IN),
    .set_in   (rel_evt[7:0]), // RULE2
    .rd_clr_in(rd_hi),
    .flags_out(flags_hi)
  );

  // Read mux; unmapped offsets answer zero so a stray read has no effect.
  always_comb begin
    nxt_rd_valid = REG_RD_IN;
    nxt_rd_data  = rd_data_ff;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `KES_ADDR_REL_LO:  nxt_rd_data = flags_lo; // RULE1
        `KES_ADDR_REL_HI:  nxt_rd_data = flags_hi; // RULE2
        `KES_ADDR_LIVE_LO: nxt_rd_data = live_ff[15:8]; // RULE5
        `KES_ADDR_LIVE_HI: nxt_rd_data = live_ff[7:0]; // RULE7
        default:           nxt_rd_data = `KES_UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rd_data_ff  <= `KES_RST_FLAGS;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign RD_DATA_OUT  = rd_data_ff;
  assign RD_VALID_OUT = rd_valid_ff;

  sequence s_release_lo;
    rel_evt[15:8] != 8'h00;
  endsequence

  sequence s_read_lo;
    rd_lo;
  endsequence

  sequence s_release_hi;
    rel_evt[7:0] != 8'h00;
  endsequence

  sequence s_read_hi;
    rd_hi;
  endsequence

  // Read-back checks allow older pending flags beside the new release,
  // since the host may leave a register unread across several releases.
  a_rel_lo_read: assert property ( // RULE1
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    s_release_lo ##1 (s_read_lo and (rel_evt[15:8] == 8'h00))
    |=> ((RD_DATA_OUT & $past(rel_evt[15:8], 2)) ==
         $past(rel_evt[15:8], 2)) && RD_VALID_OUT && (flags_lo == 8'h00))
    else $error("Release of a key A to H not read back in its bit.");

  a_rel_lo_set: assert property ( // RULE1
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    s_release_lo |=> ((flags_lo & $past(rel_evt[15:8])) ==
                      $past(rel_evt[15:8])))
    else $error("Release of a key A to H did not set its flag.");

  a_rel_hi_read: assert property ( // RULE2
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    s_release_hi ##1 (s_read_hi and (rel_evt[7:0] == 8'h00))
    |=> ((RD_DATA_OUT & $past(rel_evt[7:0], 2)) ==
         $past(rel_evt[7:0], 2)) && RD_VALID_OUT && (flags_hi == 8'h00))
    else $error("Release of a key I to P not read back in its bit.");

  a_rel_hi_set: assert property ( // RULE2
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    s_release_hi |=> ((flags_hi & $past(rel_evt[7:0])) ==
                      $past(rel_evt[7:0])))
    else $error("Release of a key I to P did not set its flag.");

  a_flag_no_cause: assert property ( // RULE3
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    ((flags_lo & ~$past(flags_lo) & ~$past(rel_evt[15:8])) == 8'h00) &&
    ((flags_hi & ~$past(flags_hi) & ~$past(rel_evt[7:0])) == 8'h00))
    else $error("Release flag set with no release of its key.");

  a_read_clears: assert property ( // RULE4
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (s_read_lo and (rel_evt[15:8] == 8'h00))
    |=> (flags_lo == 8'h00) && (RD_DATA_OUT == $past(flags_lo)))
    else $error("Read of release flags did not return and clear them.");

  a_read_clears_hi: assert property ( // RULE4
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (s_read_hi and (rel_evt[7:0] == 8'h00))
    |=> (flags_hi == 8'h00) && (RD_DATA_OUT == $past(flags_hi)))
    else $error("Read of keys I to P flags did not return and clear them.");

  a_lo_keeps_hi: assert property ( // RULE4
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    s_read_lo |=> ((flags_hi & $past(flags_hi)) == $past(flags_hi)))
    else $error("Read of keys A to H flags cleared keys I to P flags.");

  a_hi_keeps_lo: assert property ( // RULE4
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    s_read_hi |=> ((flags_lo & $past(flags_lo)) == $past(flags_lo)))
    else $error("Read of keys I to P flags cleared keys A to H flags.");

  a_live_lo_read: assert property ( // RULE5
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rd_live_lo && $past(RSTN_IN)) |=> RD_VALID_OUT &&
      (RD_DATA_OUT == $past(KEY_STATE_IN[15:8], 2)))
    else $error("Live state of keys A to H read back wrong.");

  a_live_no_latch: assert property ( // RULE6
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rd_live_lo || rd_live_hi) ##1 1'b1 |=> (live_ff == $past(KEY_STATE_IN)))
    else $error("Live key state held or altered by a read.");

  a_live_follows: assert property ( // RULE6
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    $past(RSTN_IN) |-> (live_ff == $past(KEY_STATE_IN)))
    else $error("Live key state did not follow the keys.");

  a_live_hi_read: assert property ( // RULE7
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rd_live_hi && $past(RSTN_IN)) |=> RD_VALID_OUT &&
      (RD_DATA_OUT == $past(KEY_STATE_IN[7:0], 2)))
    else $error("Live state of keys I to P read back wrong.");

  a_unmapped_zero: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (REG_RD_IN && !(rd_lo || rd_hi || rd_live_lo || rd_live_hi))
    |=> RD_VALID_OUT && (RD_DATA_OUT == `KES_UNMAPPED_DATA))
    else $error("Read of an unmapped offset did not answer zero.");

  a_valid_follows: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    $past(RSTN_IN) |-> (RD_VALID_OUT == $past(REG_RD_IN)))
    else $error("Read valid not a one-cycle answer to a read.");

  a_data_holds: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    !REG_RD_IN |=> $stable(RD_DATA_OUT))
    else $error("Read data changed with no read taken.");

  a_rel_kept_read: assert property ( // RULE8
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (s_read_lo and s_release_lo) |=> (flags_lo == $past(rel_evt[15:8])))
    else $error("Release during a read was lost or stale flag kept.");
endmodule
`default_nettype wire

/* tb/kes_host.sv */
// Host model that reads the status registers one byte at a time.
`timescale 1ns/1ps
`default_nettype none
module kes_host (
  // Clock
  input  wire logic       clk_in,
  // Read answer from the device
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in,
  // Read request to the device
  output var  logic       rd_out,
  output var  logic [7:0] addr_out
);
  initial begin
    rd_out   = 1'b0;
    addr_out = 8'h00;
  end

  // Returns the valid flag above the data byte.
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(posedge clk_in);
    rd_out   <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    // A released address means nothing, so it is scrambled on purpose.
    addr_out <= ~a;
    #1;
    q = {rd_valid_in, rd_data_in};
  endtask
endmodule
`default_nettype wire

/* tb/kes_top_tb.sv */
// Self-checking bench for the keypad event status registers.
`timescale 1ns/1ps
`default_nettype none
`define KES_CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("unexpected at %0t got %h exp %h", $time, got, exp); \
  end \
end
module kes_top_tb;
  logic        clk;
  logic        rstn;
  logic [15:0] keys;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [8:0]  q;
  int          fails;
  int          num_checks;

  kes_top u_kes_top (
    .CORE_CLK_IN  (clk),
    .RSTN_IN      (rstn),
    .KEY_STATE_IN (keys),
    .REG_RD_IN    (rd),
    .REG_ADDR_IN  (addr),
    .RD_DATA_OUT  (rd_data),
    .RD_VALID_OUT (rd_valid)
  );

  kes_host u_kes_host (
    .clk_in      (clk),
    .rd_data_in  (rd_data),
    .rd_valid_in (rd_valid),
    .rd_out      (rd),
    .addr_out    (addr)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The tests need under a hundred cycles, so this leaves wide margin.
  initial begin
    #20000;
    fails++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    keys = 16'h0000;
    fails = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // Offsets 0x21 and 0x26 are unmapped and must answer zero.
    for (int a = 8'h21; a <= 8'h26; a++) begin
      u_kes_host.rd(8'(a), q);
      `KES_CHK(q, 9'h100)
    end
    @(posedge clk);
    keys <= 16'h8181;
    u_kes_host.rd(8'h24, q);
    `KES_CHK(q, 9'h181)
    u_kes_host.rd(8'h25, q);
    `KES_CHK(q, 9'h181)
    u_kes_host.rd(8'h22, q);
    `KES_CHK(q, 9'h100)
    @(posedge clk);
    keys <= 16'h0000;
    u_kes_host.rd(8'h22, q);
    `KES_CHK(q, 9'h181)
    u_kes_host.rd(8'h23, q);
    `KES_CHK(q, 9'h181)
    u_kes_host.rd(8'h22, q);
    `KES_CHK(q, 9'h100)
    u_kes_host.rd(8'h24, q);
    `KES_CHK(q, 9'h100)
    @(posedge clk);
    keys <= 16'h0001;
    @(posedge clk);
    keys <= 16'h0000;
    u_kes_host.rd(8'h23, q);
    `KES_CHK(q, 9'h101)
    @(posedge clk);
    keys <= 16'h4002;
    repeat (2) @(posedge clk);
    // The release lands on the very edge that takes the read.
    fork
      u_kes_host.rd(8'h22, q);
      begin
        @(posedge clk);
        keys <= 16'h0000;
      end
    join
    `KES_CHK(q, 9'h100)
    u_kes_host.rd(8'h22, q);
    `KES_CHK(q, 9'h140)
    u_kes_host.rd(8'h23, q);
    `KES_CHK(q, 9'h102)
    report_and_stop();
  end
endmodule
`default_nettype wire
